/* inc/ipfe_pkg.sv */
package ipfe_pkg;
	localparam int unsigned EXT_N = 4;
	localparam int unsigned SRC_N = 5;
	localparam int unsigned SEL_W = 5;
	localparam int unsigned AW = 8;
	localparam logic [AW-1:0] OFS_POLARITY = 8'h00;
	localparam logic [AW-1:0] OFS_SELECT = 8'h04;
	localparam logic [AW-1:0] OFS_STATUS = 8'h08;
	localparam logic [AW-1:0] OFS_CLEAR = 8'h0C;
	localparam logic [AW-1:0] OFS_ENABLE = 8'h10;
	localparam logic [AW-1:0] OFS_PENDING = 8'h14;
	localparam logic [AW-1:0] OFS_LAST = 8'h18;
	localparam logic [3:0] POL_RST = 4'hF;
	localparam logic [19:0] SELECT_RST = 20'h398A4;
	localparam logic [SEL_W-1:0] SEL_EXT_BASE = 5'h04;
	localparam logic [4:0] ENABLE_RST = 5'h00;
	localparam logic [3:0] NUM_NMI = 4'h1;
	localparam logic [3:0] NUM_EXT_BASE = 4'h4;
	localparam logic [1:0] SYNC_FULL = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] fill;
		logic s1;
		logic s2;
		logic s3;
	} ipfe_sync_t;

	typedef struct packed {
		logic aw_held;
		logic w_held;
		logic [AW-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rd_busy;
		logic [AW-1:0] raddr;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ipfe_axil_t;

	typedef struct packed {
		logic [3:0] pol;
		logic [19:0] sel;
		logic [4:0] status;
		logic [4:0] enable;
		logic nmi_pend;
		logic [3:0] slot_pend;
		logic ack;
		logic [3:0] num;
	} ipfe_core_t;

	function automatic logic ipfe_known(input logic [AW-1:0] a);
		return a == OFS_POLARITY || a == OFS_SELECT || a == OFS_STATUS ||
			a == OFS_CLEAR || a == OFS_ENABLE || a == OFS_PENDING ||
			a == OFS_LAST;
	endfunction

	function automatic logic [31:0] ipfe_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

/* verilog/ipfe_edge_sync.sv */
module ipfe_edge_sync
	import ipfe_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic pin,
	input wire logic rise_sel,
	output logic evt
);
	ipfe_sync_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.fill != SYNC_FULL) begin
			st_d.fill = st_q.fill + 2'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// blind until the chain holds real pin history, so a pin already
	// active at reset is not taken for an edge
	assign evt = (st_q.fill == SYNC_FULL) && (rise_sel ?
		(st_q.s2 && !st_q.s3) : (!st_q.s2 && st_q.s3));
endmodule // ipfe_edge_sync

/* verilog/ipfe_axil.sv */
module ipfe_axil
	import ipfe_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_fire,
	output logic [AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [AW-1:0] rd_addr,
	input wire logic [31:0] rd_data
);
	ipfe_axil_t st_q, st_d;

	assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
	assign s_axi_wready = !st_q.w_held && !st_q.bvalid;
	assign s_axi_arready = !st_q.rd_busy && !st_q.rvalid;
	assign wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;

	always_comb begin
		st_d = st_q;
		if (s_axi_awvalid && s_axi_awready) begin
			st_d.aw_held = 1'b1;
			st_d.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_d.w_held = 1'b1;
			st_d.wdata = s_axi_wdata;
			st_d.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			st_d.aw_held = 1'b0;
			st_d.w_held = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = ipfe_known(st_q.waddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_d.rd_busy = 1'b1;
			st_d.raddr = s_axi_araddr;
		end
		if (st_q.rd_busy) begin
			st_d.rd_busy = 1'b0;
			st_d.rvalid = 1'b1;
			st_d.rdata = rd_data;
			st_d.rresp = ipfe_known(st_q.raddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign s_axi_bresp = st_q.bresp;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign s_axi_rvalid = st_q.rvalid;
	assign wr_addr = st_q.waddr;
	assign wr_data = st_q.wdata;
	assign wr_strb = st_q.wstrb;
	assign rd_addr = st_q.raddr;
endmodule // ipfe_axil

/* verilog/ipfe_top.sv */
// Function
// RULE_01 - The nonmaskable input raises a request only on a low-to-high edge.
// RULE_02 - Each external pin is edge-detected with its own polarity bit.
// RULE_03 - The acknowledge pulses whenever the core services any interrupt.
// RULE_04 - A four-bit number names the serviced interrupt during acknowledge.
// RULE_05 - The number follows the service slot order, one number per slot.
// RULE_06 - Outside logic samples the number only while acknowledge is high.
// RULE_07 - After reset the four pins route to slots four to seven by default.
// RULE_08 - Inputs are synchronised and an event stays pending until serviced.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
module ipfe_top
	import ipfe_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic nmi_pin,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	input wire logic ext_irq_pin_c,
	input wire logic ext_irq_pin_d,
	input wire logic core_svc_valid,
	input wire logic [3:0] core_svc_num,
	output logic core_nmi_req,
	output logic [3:0] core_ext_req,
	output logic irq_ack_strobe,
	output logic [3:0] serviced_irq_number,
	output logic irq,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	ipfe_core_t st_q, st_d;
	logic [SRC_N-1:0] src_pin;
	logic [SRC_N-1:0] src_rise;
	logic [SRC_N-1:0] src_evt;
	logic nmi_evt;
	logic [EXT_N-1:0] ext_evt;
	logic [EXT_N-1:0] slot_set;
	logic [EXT_N-1:0] slot_clr;
	logic wr_fire;
	logic [AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [AW-1:0] rd_addr;
	logic [31:0] rd_data;
	logic [31:0] ext_irq_polarity_field;
	logic [31:0] sel_word;
	logic [31:0] en_word;
	logic [31:0] pol_merged;
	logic [31:0] sel_merged;
	logic [31:0] clr_merged;
	logic [31:0] en_merged;

	assign src_pin = {ext_irq_pin_d, ext_irq_pin_c, ext_irq_pin_b,
		ext_irq_pin_a, nmi_pin};
	// the nonmaskable source has no polarity choice: rising only
	assign src_rise = {st_q.pol, 1'b1}; // RULE_01

	genvar g;
	generate
		for (g = 0; g < SRC_N; g++) begin : gen_src
			ipfe_edge_sync u_edge (
				.mclk(mclk),
				.rst_b(rst_b),
				.pin(src_pin[g]),
				.rise_sel(src_rise[g]),
				.evt(src_evt[g])
			); // RULE_02 RULE_08
		end
	endgenerate

	assign nmi_evt = src_evt[0];
	assign ext_evt = src_evt[SRC_N-1:1];

	ipfe_axil u_bus (
		.mclk(mclk),
		.rst_b(rst_b),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_fire(wr_fire),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	assign ext_irq_polarity_field = {28'h0000000, st_q.pol};
	assign sel_word = {12'h000, st_q.sel};
	assign en_word = {27'h0000000, st_q.enable};

	// byte lanes act on the full word; the field is cut out afterwards
	assign pol_merged = ipfe_merge(ext_irq_polarity_field, wr_data, wr_strb);
	assign sel_merged = ipfe_merge(sel_word, wr_data, wr_strb);
	assign clr_merged = ipfe_merge(32'h00000000, wr_data, wr_strb);
	assign en_merged = ipfe_merge(en_word, wr_data, wr_strb);

	// a slot takes the event of whichever pin its selector code names;
	// codes outside the pin range belong to sources elsewhere in the chip
	always_comb begin
		slot_set = '0;
		slot_clr = '0;
		for (int k = 0; k < EXT_N; k++) begin
			for (int j = 0; j < EXT_N; j++) begin
				if (st_q.sel[k*SEL_W +: SEL_W] == SEL_EXT_BASE + SEL_W'(j) &&
					ext_evt[j]) begin
					slot_set[k] = 1'b1; // RULE_07
				end
			end
			slot_clr[k] = core_svc_valid &&
				core_svc_num == NUM_EXT_BASE + 4'(k); // RULE_05
		end
	end

	always_comb begin
		if (rd_addr == OFS_POLARITY) begin
			rd_data = ext_irq_polarity_field;
		end else if (rd_addr == OFS_SELECT) begin
			rd_data = sel_word;
		end else if (rd_addr == OFS_STATUS) begin
			rd_data = {27'h0000000, st_q.status};
		end else if (rd_addr == OFS_ENABLE) begin
			rd_data = en_word;
		end else if (rd_addr == OFS_PENDING) begin
			rd_data = {27'h0000000, st_q.slot_pend, st_q.nmi_pend};
		end else if (rd_addr == OFS_LAST) begin
			rd_data = {28'h0000000, st_q.num};
		end else begin
			rd_data = 32'h00000000;
		end
	end

	always_comb begin
		st_d = st_q;
		if (wr_fire) begin
			if (wr_addr == OFS_POLARITY) begin
				st_d.pol = pol_merged[3:0];
			end else if (wr_addr == OFS_SELECT) begin
				st_d.sel = sel_merged[19:0];
			end else if (wr_addr == OFS_CLEAR) begin
				st_d.status = st_q.status & ~clr_merged[4:0];
			end else if (wr_addr == OFS_ENABLE) begin
				st_d.enable = en_merged[4:0];
			end
		end
		// set after clear, so an edge in the clearing cycle survives
		st_d.status = st_d.status | src_evt;
		// pending hold: the service clear loses to a fresh edge
		if (core_svc_valid && core_svc_num == NUM_NMI) begin
			st_d.nmi_pend = 1'b0; // RULE_08
		end
		if (nmi_evt) begin
			st_d.nmi_pend = 1'b1; // RULE_01 RULE_08
		end
		st_d.slot_pend = (st_q.slot_pend & ~slot_clr) | slot_set; // RULE_08
		// every serviced slot is acknowledged, also those fed elsewhere
		st_d.ack = core_svc_valid; // RULE_03
		if (core_svc_valid) begin
			st_d.num = core_svc_num; // RULE_04 RULE_05
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_q.pol <= POL_RST;
			st_q.sel <= SELECT_RST; // RULE_07
			st_q.status <= 5'h00;
			st_q.enable <= ENABLE_RST;
			st_q.nmi_pend <= 1'b0;
			st_q.slot_pend <= 4'h0;
			st_q.ack <= 1'b0;
			st_q.num <= 4'h0;
		end else begin
			st_q <= st_d;
		end
	end

	assign core_nmi_req = st_q.nmi_pend;
	assign core_ext_req = st_q.slot_pend;
	assign irq_ack_strobe = st_q.ack; // RULE_03
	// the number is held after the pulse, but only meaningful during it
	assign serviced_irq_number = st_q.num; // RULE_04 RULE_06
	assign irq = |(st_q.status & st_q.enable);

	a_nmi_rise_only: assert property (@(posedge mclk) disable iff (!rst_b)
		nmi_evt |-> $past(nmi_pin, 2) && !$past(nmi_pin, 3)) // RULE_01
		else $error("nmi event without a rising edge");

	generate
		for (g = 0; g < EXT_N; g++) begin : gen_chk
			a_ext_edge_pol: assert property (@(posedge mclk)
				disable iff (!rst_b)
				ext_evt[g] |-> (st_q.pol[g] ?
				($past(src_pin[g+1], 2) && !$past(src_pin[g+1], 3)) :
				(!$past(src_pin[g+1], 2) && $past(src_pin[g+1], 3))))
				// RULE_02
				else $error("external event against polarity");

			a_slot_svc_clear: assert property (@(posedge mclk)
				disable iff (!rst_b)
				core_svc_valid && core_svc_num == NUM_EXT_BASE + 4'(g) &&
				!slot_set[g] |=> !core_ext_req[g]) // RULE_05
				else $error("serviced slot still pending");

			a_ext_pend_set: assert property ( // RULE_08
				@(posedge mclk) disable iff (!rst_b)
				slot_set[g] |=> core_ext_req[g])
				else $error("slot event not held pending");

			a_ext_pend_hold: assert property ( // RULE_08
				@(posedge mclk) disable iff (!rst_b)
				core_ext_req[g] && !slot_clr[g] |=> core_ext_req[g])
				else $error("slot pending dropped without service");

			a_ext_no_spurious: assert property ( // RULE_08
				@(posedge mclk) disable iff (!rst_b)
				!slot_set[g] && !core_ext_req[g] |=> !core_ext_req[g])
				else $error("slot pending without an event");
		end
	endgenerate

	a_ack_follows_svc: assert property (@(posedge mclk) disable iff (!rst_b)
		core_svc_valid |=> irq_ack_strobe ##1
		(irq_ack_strobe == $past(core_svc_valid))) // RULE_03
		else $error("acknowledge missing after service");

	a_num_during_ack: assert property (@(posedge mclk) disable iff (!rst_b)
		irq_ack_strobe |-> serviced_irq_number == $past(core_svc_num)
		&& $past(core_svc_valid)) // RULE_04
		else $error("wrong number during acknowledge");

	a_sel_default: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(rst_b) |-> st_q.sel == SELECT_RST) // RULE_07
		else $error("selector not at default after reset");

	a_default_route: assert property (@(posedge mclk) disable iff (!rst_b)
		ext_evt[0] && st_q.sel == SELECT_RST |=> core_ext_req[0]) // RULE_07
		else $error("pin a not routed to slot four");

	a_pend_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		core_nmi_req && !(core_svc_valid && core_svc_num == NUM_NMI)
		|=> core_nmi_req [*1]) // RULE_08
		else $error("nmi pending dropped without service");

	a_nmi_pend_set: assert property (@(posedge mclk) disable iff (!rst_b)
		nmi_evt |=> core_nmi_req && st_q.status[0]) // RULE_08
		else $error("nmi event not held");

	a_irq_level: assert property (@(posedge mclk) disable iff (!rst_b)
		(st_q.status & st_q.enable) != 5'h00 |-> irq)
		else $error("enabled status without interrupt");

	a_irq_low: assert property (
		@(posedge mclk) disable iff (!rst_b)
		(st_q.status & st_q.enable) == 5'h00 |-> !irq)
		else $error("interrupt without an enabled status");

	a_ack_only_svc: assert property ( // RULE_03
		@(posedge mclk) disable iff (!rst_b)
		irq_ack_strobe |-> $past(core_svc_valid))
		else $error("acknowledge without a service");

	a_num_held: assert property ( // RULE_04
		@(posedge mclk) disable iff (!rst_b)
		!core_svc_valid |=> $stable(serviced_irq_number))
		else $error("number changed without a service");

	a_nmi_no_spurious: assert property ( // RULE_01
		@(posedge mclk) disable iff (!rst_b)
		!nmi_evt && !core_nmi_req |=> !core_nmi_req)
		else $error("nmi pending without an edge");

	a_nmi_svc_clear: assert property ( // RULE_08
		@(posedge mclk) disable iff (!rst_b)
		core_svc_valid && core_svc_num == NUM_NMI && !nmi_evt
		|=> !core_nmi_req)
		else $error("serviced nmi still pending");

	a_status_sticky: assert property ( // RULE_08
		@(posedge mclk) disable iff (!rst_b)
		!(wr_fire && wr_addr == OFS_CLEAR) |=>
		(st_q.status & $past(st_q.status)) == $past(st_q.status))
		else $error("status bit lost without a clear");

	a_blind_start: assert property ( // RULE_08
		@(posedge mclk) disable iff (!rst_b)
		$rose(rst_b) |-> src_evt == 5'h00 ##1 src_evt == 5'h00)
		else $error("event seen before pin history filled");
endmodule // ipfe_top

/* bench/ipfe_src_model.sv */
module ipfe_src_model
	import ipfe_pkg::*;
(
	input wire logic mclk,
	input wire logic irq_ack_strobe,
	input wire logic [3:0] serviced_irq_number,
	output logic nmi_pin,
	output logic [EXT_N-1:0] ext_pin,
	output logic [3:0] seen_num
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		nmi_pin = 1'h0;
		ext_pin = 4'h0;
		seen_num = 4'h0;
	end
	// board levels; each change lands just after an edge
	task automatic drive(input logic [4:0] v);
		@(posedge mclk);
		{ext_pin, nmi_pin} <= v;
	endtask
	// the number is only trusted inside the acknowledge cycle
	always @(posedge mclk) begin
		if (irq_ack_strobe === 1'h1) begin
			seen_num <= serviced_irq_number;
		end
	end
endmodule // ipfe_src_model

/* bench/ipfe_top_tb.sv */
module ipfe_top_tb;
	import ipfe_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk;
	logic rst_b;
	logic svc_v;
	logic [3:0] svc_n;
	logic nmi;
	logic [3:0] ext;
	logic nmi_req;
	logic [3:0] ext_req;
	logic ack;
	logic [3:0] num;
	logic [3:0] seen;
	logic irq;
	logic [AW-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int n_errors = 0;
	int comparisons = 0;

	ipfe_src_model ipfe_src_model_inst (.mclk(mclk), .irq_ack_strobe(ack),
		.serviced_irq_number(num), .nmi_pin(nmi), .ext_pin(ext),
		.seen_num(seen));

	ipfe_top ipfe_top_inst (.mclk(mclk), .rst_b(rst_b), .nmi_pin(nmi),
		.ext_irq_pin_a(ext[0]), .ext_irq_pin_b(ext[1]),
		.ext_irq_pin_c(ext[2]), .ext_irq_pin_d(ext[3]),
		.core_svc_valid(svc_v), .core_svc_num(svc_n),
		.core_nmi_req(nmi_req), .core_ext_req(ext_req),
		.irq_ack_strobe(ack), .serviced_irq_number(num), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	task automatic final_report;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic done;
		logic [1:0] r;
		done = 1'h0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!done) begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			done = bvalid;
			r = bresp;
		end
		bready <= 1'h0;
		chk(32'(r), 32'(RESP_OKAY));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic done;
		logic [31:0] d;
		logic [1:0] r;
		done = 1'h0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (!done) begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
			done = rvalid;
			d = rdata;
			r = rresp;
		end
		rready <= 1'h0;
		chk(d, e);
		chk(32'(r), 32'(er));
	endtask

	// six edges cover the three-stage sync plus the pending update
	task automatic pin(input logic [4:0] v);
		ipfe_src_model_inst.drive(v);
		cyc(6);
		#1;
	endtask

	task automatic svc(input logic [3:0] n);
		@(posedge mclk);
		svc_v <= 1'h1;
		svc_n <= n;
		@(posedge mclk);
		svc_v <= 1'h0;
		#1;
		chk(32'(ack), 32'h1);
		chk(32'(num), 32'(n));
		@(posedge mclk);
		#1;
		chk(32'(ack), 32'h0);
		chk(32'(seen), 32'(n));
	endtask

	task automatic scn_reset;
		rd(OFS_POLARITY, 32'hF, RESP_OKAY);
		rd(OFS_SELECT, {12'h0, 5'h07, 5'h06, 5'h05, 5'h04}, RESP_OKAY);
		rd(OFS_ENABLE, 32'h0, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
	endtask

	task automatic scn_nmi;
		pin(5'h01);
		chk(32'(nmi_req), 32'h1);
		rd(OFS_STATUS, 32'h1, RESP_OKAY);
		rd(OFS_PENDING, 32'h1, RESP_OKAY);
		wr(OFS_CLEAR, 32'h1F);
		cyc(6);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		chk(32'(nmi_req), 32'h1);
		pin(5'h00);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		svc(NUM_NMI);
		chk(32'(nmi_req), 32'h0);
		rd(OFS_LAST, 32'(NUM_NMI), RESP_OKAY);
	endtask

	task automatic scn_ext;
		for (int j = 0; j < 4; j++) begin
			pin(5'(2 << j));
			chk(32'(ext_req), 32'(1 << j));
			svc(4'(4 + j));
			chk(32'(ext_req), 32'h0);
			pin(5'h00);
			chk(32'(ext_req), 32'h0);
			wr(OFS_POLARITY, 32'(4'hF ^ (4'h1 << j)));
			pin(5'(2 << j));
			chk(32'(ext_req), 32'h0);
			pin(5'h00);
			chk(32'(ext_req), 32'(1 << j));
			svc(4'(4 + j));
			wr(OFS_POLARITY, 32'hF);
		end
		rd(OFS_STATUS, 32'h1E, RESP_OKAY);
		wr(OFS_CLEAR, 32'h1E);
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		// slot four rerouted to pin b: both slots fire on one edge
		wr(OFS_SELECT, {12'h0, 5'h07, 5'h06, 5'h05, 5'h05});
		pin(5'h04);
		chk(32'(ext_req), 32'h3);
		rd(OFS_PENDING, 32'h6, RESP_OKAY);
		pin(5'h00);
		svc(4'h4);
		svc(4'h5);
		wr(OFS_SELECT, {12'h0, 5'h07, 5'h06, 5'h05, 5'h04});
		wr(OFS_CLEAR, 32'h1F);
	endtask

	task automatic scn_irq;
		wr(OFS_ENABLE, 32'h2);
		chk(32'(irq), 32'h0);
		pin(5'h02);
		chk(32'(irq), 32'h1);
		wr(OFS_ENABLE, 32'h0);
		chk(32'(irq), 32'h0);
		wr(OFS_ENABLE, 32'h2);
		chk(32'(irq), 32'h1);
		wr(OFS_CLEAR, 32'h2);
		chk(32'(irq), 32'h0);
		pin(5'h00);
		svc(4'h4);
		svc(4'h9);
		rd(OFS_LAST, 32'h9, RESP_OKAY);
	endtask

	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		final_report();
	end

	initial begin
		rst_b = 1'h0;
		svc_v = 1'h0;
		svc_n = 4'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		awvalid = 1'h0;
		wvalid = 1'h0;
		bready = 1'h0;
		arvalid = 1'h0;
		rready = 1'h0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'h1;
		// edge detectors stay blind while their history fills
		cyc(4);
		scn_reset();
		scn_nmi();
		scn_ext();
		scn_irq();
		final_report();
	end
endmodule // ipfe_top_tb
